// ==== hw/mwdt_pkg.sv ====
package mwdt_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] MWDT_ARM_CONTROL_ADDR = 16'h0455;
  localparam int          MWDT_ARM_BIT          = 7;
  localparam logic [7:0]  MWDT_ARM_CONTROL_RST  = 8'h00;

  // ==========================================================
  // Timing
  // Nominal timeout; the checks accept half to one and a half times this
  localparam longint MWDT_CLK_HZ      = 64'h0BEBC200;
  localparam longint MWDT_TIMEOUT_MS  = 64'h44C;
  localparam longint MWDT_TIMEOUT_CYC = (MWDT_TIMEOUT_MS * MWDT_CLK_HZ) / 64'h3E8;
  localparam int     MWDT_CNT_W       = 28;
  localparam int     MWDT_RST_PULSE   = 16;
  localparam logic [4:0] MWDT_PULSE_W = 5'(MWDT_RST_PULSE);

  // ==========================================================
  // I/O request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mwdt_io_req_t;

endpackage

// ==== hw/mwdt_module_watchdog_timer.sv ====
module mwdt_module_watchdog_timer
  import mwdt_pkg::*;
#(
  parameter longint TIMEOUT_CYC = MWDT_TIMEOUT_CYC
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         platform_enable,
  input  wire mwdt_io_req_t io_req,
  output logic              io_rd_hit,
  output logic [7:0]        io_rdata,
  output logic              module_reset
);

  // Last count before expiry; the cast keeps the compare at counter width
  localparam logic [MWDT_CNT_W-1:0] LIMIT      = MWDT_CNT_W'(TIMEOUT_CYC - 64'h1);
  // Pulse length seen on the last cycle of a full reset pulse
  localparam logic [4:0]            PULSE_LAST = MWDT_PULSE_W - 5'h01;

  logic                  en_meta;
  logic                  en_sync;
  logic                  armed;
  logic [MWDT_CNT_W-1:0] count;
  logic [4:0]            pulse_cnt;
  logic [4:0]            pulse_seen;
  logic                  hit;
  logic                  read_hit;
  logic                  access_hit;
  logic                  expire;

  // ==========================================================
  // Platform option synchroniser; the option pin is a strap, not clocked here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_meta <= 1'h0;
      en_sync <= 1'h0;
    end
    else
    begin
      en_meta <= platform_enable;
      en_sync <= en_meta;
    end
  end

  // ==========================================================
  // Port decode only while enabled; a disabled port is simply not there
  assign hit        = en_sync && (io_req.addr == MWDT_ARM_CONTROL_ADDR);
  assign read_hit   = hit && io_req.rd;
  assign access_hit = hit && (io_req.rd || io_req.wr);

  // ==========================================================
  // Arm state; a running watchdog reset or a disabled option clears it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed <= 1'h0;
    else if (!en_sync || pulse_cnt != 5'h00)
      armed <= 1'h0;
    else if (hit && io_req.wr)
      armed <= io_req.wdata[MWDT_ARM_BIT];
  end

  // ==========================================================
  // Timeout counter, held at zero while disarmed
  // Any decoded access restarts it, so an arming write starts a full interval
  assign expire = armed && (count == LIMIT);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (!armed || access_hit)
      count <= '0;
    else if (!expire)
      count <= count + 1'h1;
  end

  // ==========================================================
  // Reset pulse of fixed width so the whole reset tree sees it
  // A read in the expiry cycle still counts as a refresh and wins
  // No reload while a pulse runs, else the pulse would stretch by a cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulse_cnt <= 5'h00;
    else if (expire && !read_hit && pulse_cnt == 5'h00)
      pulse_cnt <= MWDT_PULSE_W;
    else if (pulse_cnt != 5'h00)
      pulse_cnt <= pulse_cnt - 5'h01;
  end

  // Module reset straight from a flop; cut short if the option goes away
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      module_reset <= 1'h0;
    else
      module_reset <= en_sync && (pulse_cnt != 5'h00);
  end

  // ==========================================================
  // Read data: arm bit only, reserved bits zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      io_rd_hit <= 1'h0;
      io_rdata  <= MWDT_ARM_CONTROL_RST;
    end
    else
    begin
      io_rd_hit <= read_hit;
      io_rdata  <= read_hit ? {armed, 7'h00} : 8'h00;
    end
  end

  // ==========================================================
  // Length of the reset pulse so far, read by the checks only
  // Saturates so a stuck reset cannot wrap back into a legal length
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulse_seen <= 5'h00;
    else if (!module_reset)
      pulse_seen <= 5'h00;
    else if (pulse_seen != 5'h1F)
      pulse_seen <= pulse_seen + 5'h01;
  end

  // ==========================================================
  // Checks: decode and platform option
  a_disabled_no_reset: assert property (@(posedge clk) disable iff (rst)
    !en_sync |=> !module_reset)
    else $error("reset while disabled");

  a_disabled_no_hit: assert property (@(posedge clk) disable iff (rst)
    !en_sync |=> !io_rd_hit)
    else $error("read decoded while disabled");

  a_miss_ignored: assert property (@(posedge clk) disable iff (rst)
    (io_req.rd && !hit) |=> !io_rd_hit)
    else $error("foreign read answered");

  a_disable_disarms: assert property (@(posedge clk) disable iff (rst)
    !en_sync |=> !armed)
    else $error("armed while disabled");

  // ==========================================================
  // Checks: arming and disarming
  a_arm_write: assert property (@(posedge clk) disable iff (rst)
    (hit && io_req.wr && io_req.wdata[MWDT_ARM_BIT] && pulse_cnt == 5'h00) |=> armed)
    else $error("arm failed");

  a_disarm_write: assert property (@(posedge clk) disable iff (rst)
    (hit && io_req.wr && !io_req.wdata[MWDT_ARM_BIT]) |=> !armed)
    else $error("disarm failed");

  a_no_self_arm: assert property (@(posedge clk) disable iff (rst)
    (!armed && !(hit && io_req.wr)) |=> !armed)
    else $error("armed without write");

  a_reset_disarms: assert property (@(posedge clk) disable iff (rst)
    (pulse_cnt != 5'h00) |=> !armed)
    else $error("arm survived reset");

  // ==========================================================
  // Checks: interval counting and refresh
  a_read_refresh: assert property (@(posedge clk) disable iff (rst)
    (read_hit && armed) |=> (count == '0))
    else $error("read did not refresh");

  a_write_restart: assert property (@(posedge clk) disable iff (rst)
    (hit && io_req.wr && io_req.wdata[MWDT_ARM_BIT] && pulse_cnt == 5'h00) |=> (count == '0))
    else $error("arm did not start interval");

  a_count_steps: assert property (@(posedge clk) disable iff (rst)
    (armed && !access_hit && !expire) |=> (count == $past(count) + 1'h1))
    else $error("count skipped or stalled");

  a_disarmed_idle: assert property (@(posedge clk) disable iff (rst)
    !armed |=> (count == '0))
    else $error("count ran disarmed");

  a_count_bound: assert property (@(posedge clk) disable iff (rst)
    count <= LIMIT)
    else $error("count passed its limit");

  // ==========================================================
  // Checks: expiry and the reset pulse
  a_expire_reset: assert property (@(posedge clk) disable iff (rst)
    (expire && !read_hit && en_sync) ##1 en_sync |=> module_reset)
    else $error("timeout gave no reset");

  a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    (module_reset && en_sync && pulse_seen != PULSE_LAST) |=> module_reset)
    else $error("reset pulse ended early");

  a_pulse_bound: assert property (@(posedge clk) disable iff (rst)
    module_reset |-> (pulse_seen < MWDT_PULSE_W))
    else $error("reset pulse too long");

  // ==========================================================
  // Checks: read data
  a_readback: assert property (@(posedge clk) disable iff (rst)
    read_hit |=> (io_rdata == {$past(armed), 7'h00}))
    else $error("bad readback");

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !read_hit |=> (io_rdata == 8'h00 && !io_rd_hit))
    else $error("read data without read");

endmodule // mwdt_module_watchdog_timer

// ==== tb/tb_module_watchdog_timer.sv ====
module tb_module_watchdog_timer
  import mwdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Short timeout keeps the run brief
  localparam longint TCYC = 50;
  logic         clk             = 1'h0;
  logic         rst             = 1'h1;
  logic         platform_enable = 1'h1;
  mwdt_io_req_t io_req          = '0;
  logic         io_rd_hit;
  logic [7:0]   io_rdata;
  logic         module_reset;
  int           errors          = 0;
  int           comparisons     = 0;
  mwdt_module_watchdog_timer #(.TIMEOUT_CYC(TCYC)) DUT (.clk(clk), .rst(rst), .platform_enable(platform_enable),
    .io_req(io_req), .io_rd_hit(io_rd_hit), .io_rdata(io_rdata), .module_reset(module_reset));
  initial forever #2.5 clk = ~clk;
  // ==========================================
  // Access and compare tasks, driven on falling edges
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic rd, input logic [15:0] addr, input logic [7:0] wdata);
    @(negedge clk);
    io_req = {rd, ~rd, addr, wdata};
    @(negedge clk);
    io_req = '0;
  endtask
  // Answer is registered, so it shows at the falling edge after the strobe
  task automatic rd_chk(input logic [15:0] addr, input logic [7:0] hit, input logic [7:0] data);
    access(1'h1, addr, 8'h00);
    check(io_rd_hit, hit);
    check(io_rdata, data);
  endtask
  task automatic quiet(input longint n);
    repeat (n)
    begin
      @(negedge clk);
      check(module_reset, 1'h0);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for expiry; window allows the half-to-one-and-a-half spread
  task automatic expire();
    longint n;
    n = 0;
    while (module_reset !== 1'h1 && n < 2 * TCYC)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= TCYC / 2 && n <= TCYC * 3 / 2 + 4, 1'h1);
    if (n >= 2 * TCYC)
      complete_run();
  endtask
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    rd_chk(16'h0455, 8'h01, 8'h00);
    quiet(2 * TCYC);
    $display("test unarmed done");
    access(1'h0, 16'h0455, 8'hFF);
    rd_chk(16'h0454, 8'h00, 8'h00);
    rd_chk(16'h0455, 8'h01, 8'h80);
    repeat (4)
    begin
      quiet(TCYC / 2 - 5);
      rd_chk(16'h0455, 8'h01, 8'h80);
    end
    expire();
    // Pulse is held for its full fixed width, then drops
    repeat (MWDT_RST_PULSE - 1) @(negedge clk);
    check(module_reset, 1'h1);
    @(negedge clk);
    check(module_reset, 1'h0);
    repeat (8) @(negedge clk);
    rd_chk(16'h0455, 8'h01, 8'h00);
    $display("test expiry done");
    access(1'h0, 16'h0455, 8'h80);
    quiet(TCYC / 4);
    rd_chk(16'h0455, 8'h01, 8'h80);
    access(1'h0, 16'h0455, 8'h7F);
    rd_chk(16'h0455, 8'h01, 8'h00);
    quiet(2 * TCYC);
    $display("test disarm done");
    // Armed when the option goes away: no reset, and it comes back disarmed
    access(1'h0, 16'h0455, 8'h80);
    platform_enable = 1'h0;
    repeat (3) @(negedge clk);
    access(1'h0, 16'h0455, 8'h80);
    rd_chk(16'h0455, 8'h00, 8'h00);
    quiet(2 * TCYC);
    platform_enable = 1'h1;
    repeat (3) @(negedge clk);
    rd_chk(16'h0455, 8'h01, 8'h00);
    $display("test disabled done");
    complete_run();
  end
endmodule // tb_module_watchdog_timer
